// >>> design/ppm_pkg.sv
package ppm_pkg;
   // Clock and instruction-cycle timing.
   localparam int CLK_PERIOD_NS = 5;
   localparam int TCY_NS        = 10;
   localparam int TCY_CLKS      = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TCY_CNT_W     = 4;
   localparam logic [TCY_CNT_W-1:0] TCY_LAST = TCY_CNT_W'(TCY_CLKS - 1);

   // Register byte offsets.
   localparam logic [7:0] PPM_CON_OFS  = 8'h00;
   localparam logic [7:0] PPM_MODE_OFS = 8'h04;
   localparam logic [7:0] PPM_ADDR_OFS = 8'h08;
   localparam logic [7:0] PPM_AEN_OFS  = 8'h0c;
   localparam logic [7:0] PPM_DATA_OFS = 8'h10;

   // Reset values and writable-bit masks.
   localparam logic [15:0] PPM_CON_RST   = 16'h0000;
   localparam logic [15:0] PPM_MODE_RST  = 16'h0000;
   localparam logic [15:0] PPM_ADDR_RST  = 16'h0000;
   localparam logic [15:0] PPM_AEN_RST   = 16'h0000;
   localparam logic [15:0] PPM_CON_WMASK = 16'hbfff;

   // Control register fields.
   localparam int CON_ON = 15, CON_SIDL = 13, CON_MUX_HI = 12, CON_MUX_LO = 11;
   localparam int CON_BE = 10, CON_WR = 9, CON_RD = 8;
   localparam int CON_CSF_HI = 7, CON_CSF_LO = 6, CON_ALP = 5;
   localparam int CON_SEL_TWO_POLARITY = 4, CON_SEL_ONE_POLARITY = 3, CON_BEP = 2;
   localparam int CON_WR_STROBE_POLARITY = 1, CON_RD_STROBE_POLARITY = 0;

   // Mode register fields.
   localparam int MODE_BUSY = 15, MODE_IRQ_HI = 14, MODE_IRQ_LO = 13;
   localparam int MODE_INC_HI = 12, MODE_INC_LO = 11, MODE_WIDE = 10;
   localparam int MODE_SEL_HI = 9, MODE_SEL_LO = 8;
   localparam int MODE_SET_HI = 7, MODE_SET_LO = 6;
   localparam int MODE_STB_HI = 5, MODE_STB_LO = 2;
   localparam int MODE_HLD_HI = 1, MODE_HLD_LO = 0;

   // Address register fields.
   localparam int ADDR_SEL2 = 15, ADDR_SEL1 = 14, ADDR_STEP_W = 11;

   // Field codes.
   localparam logic [1:0] MUX_FULL = 2'h2, MUX_PART = 2'h1;
   localparam logic [1:0] CSF_BOTH = 2'h2, CSF_TWO = 2'h1;
   localparam logic [1:0] IRQ_END = 2'h1, IRQ_STALL = 2'h2;
   localparam logic [1:0] INC_UP = 2'h1, INC_DOWN = 2'h2;
   localparam logic [1:0] SEL_M1 = 2'h3, SEL_M2 = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ALO, ST_AHI, ST_SETUP, ST_STRB, ST_HOLD, ST_GAP
   } ppm_state_t;
endpackage

// >>> design/ppm_tick.sv
`timescale 1ns/10ps
`default_nettype none
module ppm_tick
   import ppm_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic run_en,
   output logic      tick
);
   logic [TCY_CNT_W-1:0] div_q;

   // The divider holds still while stopped so a frozen phase keeps its place.
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         div_q <= '0;
      else if (run_en)
         div_q <= (div_q == TCY_LAST) ? '0 : div_q + 1'b1;
   end

   assign tick = run_en && (div_q == TCY_LAST);
endmodule
`default_nettype wire

// >>> design/ppm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ppm_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] d_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q <= '0;
         d_out  <= '0;
      end
      else
      begin
         meta_q <= d_in;
         d_out  <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> design/ppm_core.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: With port_on clear no external access happens; setting it starts the port.
// R2: With stop_when_idle set, port activity freezes during system idle.
// R3: addr_data_mux_sel picks separate, partial or full address multiplexing.
// R4: Pin-on bits connect byte enable, write/enable and read strobe pins.
// R5: chip_sel_function makes upper pins chip selects or address bits.
// R6: Latch, select and byte-enable polarity bits: set means active high.
// R7: Polarity bits do nothing where the pin serves as an address line.
// R8: wr_strobe_polarity sets write strobe, or enable strobe in master mode 1.
// R9: rd_strobe_polarity sets read strobe, or read/write strobe in mode 1.
// R10: Busy flag reads high while a master transfer is in progress.
// R11: irq_mode: none, end-of-cycle pulse, processor stall, or slave-only.
// R12: addr_step_mode adds or subtracts one on address bits 10:0 per cycle.
// R13: Wide mode makes two byte transfers per data access, else one.
// R14: Mode field selects master 1, master 2 or the two slave ports.
// R15: setup_wait gives 1 to 4 Tcy of data setup and address phase.
// R16: strobe_wait adds 0 to 15 Tcy to the strobe; zero means one Tcy.
// R17: hold_wait gives 1 to 4 Tcy of data hold after the strobe.
// R18: With strobe_wait zero, setup and hold settings are ignored.
// R19: One idle Tcy separates any two consecutive bus operations.
// R20: Address bits 15 and 14 drive select_two and select_one.
// R21: Address bits 13:0 hold the destination address of transfers.
// R22: pin_assign bits give each address pin to the port or general I/O.
// R23: Latch strobes pulse during the address phase before the data phase.
// R24: The external party latches on latch strobes and uses the strobe window.
module ppm_core
   import ppm_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        idle_mode,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic [7:0]  data_pins_in,
   output logic      [7:0]  data_pins_out,
   output logic             data_pins_oe_n,
   output logic      [15:0] addr_pins_out,
   output logic      [15:0] addr_pins_oe_n,
   output logic             byte_en_out,
   output logic             byte_en_oe_n,
   output logic             wr_strobe_out,
   output logic             wr_strobe_oe_n,
   output logic             rd_strobe_out,
   output logic             rd_strobe_oe_n,
   output logic             xfer_irq,
   output logic             cpu_stall
);
   logic [15:0] con_q, mode_q, addr_q, aen_q, wr_buf_q, rd_buf_q, rd_q;
   logic        pend_q, dir_wr_q, hi_q;
   ppm_state_t  st_q, st_nx, first_st;
   logic [3:0]  cnt_q, last_cnt, strobe_wait;
   logic [7:0]  din_s;
   logic [15:0] addr_val;
   logic        tcy_en, run_en, drive_en, busy, done, phase_end;
   logic        port_on, stop_when_idle, wide, zero_wait, m1, mux_on;
   logic        data_acc, req_ok, data_phase;
   logic        cs2_act, cs1_act, wr_act, rd_act;
   logic [1:0]  mux_sel, chip_sel_function, irq_mode, step_mode, eff_setup, eff_hold;

   assign port_on        = con_q[CON_ON];
   assign stop_when_idle = con_q[CON_SIDL];
   assign mux_sel        = con_q[CON_MUX_HI:CON_MUX_LO];
   assign chip_sel_function            = con_q[CON_CSF_HI:CON_CSF_LO];
   assign irq_mode       = mode_q[MODE_IRQ_HI:MODE_IRQ_LO];
   assign step_mode      = mode_q[MODE_INC_HI:MODE_INC_LO];
   assign wide           = mode_q[MODE_WIDE];
   assign strobe_wait    = mode_q[MODE_STB_HI:MODE_STB_LO];
   assign m1             = mode_q[MODE_SEL_HI:MODE_SEL_LO] == SEL_M1; // R14
   assign mux_on         = (mux_sel == MUX_FULL) || (mux_sel == MUX_PART); // R3
   assign zero_wait      = strobe_wait == 4'h0;

   // Only the two master modes move the external bus.
   assign drive_en  = port_on && mode_q[MODE_SEL_HI]; // R1 R14
   assign run_en    = drive_en && !(stop_when_idle && idle_mode); // R2
   assign eff_setup = zero_wait ? 2'h0 : mode_q[MODE_SET_HI:MODE_SET_LO]; // R15 R18
   assign eff_hold  = zero_wait ? 2'h0 : mode_q[MODE_HLD_HI:MODE_HLD_LO]; // R17 R18
   assign busy      = (st_q != ST_IDLE) || pend_q; // R10
   assign cpu_stall = busy && (irq_mode == IRQ_STALL); // R11
   assign reg_rdata = rd_q;

   ppm_tick u_tick (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .run_en  (run_en),
      .tick    (tcy_en)
   );

   ppm_sync #(.W(8)) u_sync (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .d_in    (data_pins_in),
      .d_out   (din_s)
   );

   // Configuration registers; the busy bit and reserved bits are read-only.
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         con_q  <= PPM_CON_RST;
         mode_q <= PPM_MODE_RST;
         aen_q  <= PPM_AEN_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == PPM_CON_OFS)
            con_q <= reg_wdata & PPM_CON_WMASK;
         if (reg_addr == PPM_MODE_OFS)
            mode_q <= {1'b0, reg_wdata[MODE_IRQ_HI:0]};
         if (reg_addr == PPM_AEN_OFS)
            aen_q <= reg_wdata; // R22
      end
   end

   // Address register: a software write wins over the automatic step.
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         addr_q <= PPM_ADDR_RST;
      else if (reg_wr && reg_addr == PPM_ADDR_OFS)
         addr_q <= reg_wdata; // R21
      else if (done && step_mode == INC_UP)
         addr_q[ADDR_STEP_W-1:0] <= addr_q[ADDR_STEP_W-1:0] + 1'b1; // R12
      else if (done && step_mode == INC_DOWN)
         addr_q[ADDR_STEP_W-1:0] <= addr_q[ADDR_STEP_W-1:0] - 1'b1; // R12
   end

   // A data access while idle with drive_en set queues one bus operation; else it is dropped.
   assign data_acc = (reg_wr || reg_rd) && reg_addr == PPM_DATA_OFS;
   assign req_ok   = data_acc && drive_en && !busy;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pend_q   <= 1'b0;
         dir_wr_q <= 1'b0;
         wr_buf_q <= 16'h0000;
      end
      else if (!drive_en)
         pend_q <= 1'b0; // R1
      else if (req_ok)
      begin
         pend_q   <= 1'b1;
         dir_wr_q <= reg_wr;
         if (reg_wr)
            wr_buf_q <= reg_wdata;
      end
      else if (tcy_en && st_q == ST_IDLE)
         pend_q <= 1'b0;
   end

   // Length of each phase in Tcy, less one.
   always_comb
   begin
      case (st_q)
         ST_ALO, ST_AHI, ST_SETUP: last_cnt = {2'h0, eff_setup}; // R15
         ST_STRB:                  last_cnt = strobe_wait; // R16
         ST_HOLD:                  last_cnt = {2'h0, eff_hold}; // R17
         default:                  last_cnt = 4'h0;
      endcase
   end

   assign phase_end = cnt_q == last_cnt;
   assign first_st  = mux_on ? ST_ALO : (zero_wait ? ST_STRB : ST_SETUP); // R18
   assign done      = tcy_en && st_q == ST_GAP && !(wide && !hi_q);
   always_comb
   begin
      case (st_q)
         ST_IDLE:  st_nx = pend_q ? first_st : ST_IDLE;
         ST_ALO:   st_nx = (mux_sel == MUX_FULL) ? ST_AHI
                         : (zero_wait ? ST_STRB : ST_SETUP); // R3
         ST_AHI:   st_nx = zero_wait ? ST_STRB : ST_SETUP;
         ST_SETUP: st_nx = ST_STRB;
         ST_STRB:  st_nx = zero_wait ? ST_GAP : ST_HOLD; // R18
         ST_HOLD:  st_nx = ST_GAP; // R19
         ST_GAP:   st_nx = (wide && !hi_q) ? first_st : ST_IDLE; // R13
         default:  st_nx = ST_IDLE;
      endcase
   end

   // Bus sequencer; it steps only on Tcy enables, so it freezes with them.
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q  <= ST_IDLE;
         cnt_q <= 4'h0;
         hi_q  <= 1'b0;
      end
      else if (!drive_en)
      begin
         st_q  <= ST_IDLE; // R1
         cnt_q <= 4'h0;
         hi_q  <= 1'b0;
      end
      else if (tcy_en)
      begin
         cnt_q <= phase_end ? 4'h0 : cnt_q + 4'h1;
         if (phase_end)
            st_q <= st_nx;
         if (phase_end && st_q == ST_IDLE)
            hi_q <= 1'b0;
         else if (phase_end && st_q == ST_GAP)
            hi_q <= wide && !hi_q; // R13
      end
   end

   // Read data is taken at the close of the strobe window.
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         rd_buf_q <= 16'h0000;
      else if (tcy_en && st_q == ST_STRB && phase_end && !dir_wr_q)
         rd_buf_q <= hi_q ? {din_s, rd_buf_q[7:0]}
                          : {wide ? rd_buf_q[15:8] : 8'h00, din_s}; // R24
   end
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         xfer_irq <= 1'b0;
      else
         xfer_irq <= done && irq_mode == IRQ_END; // R11
   end

   // Register read port; unmapped offsets read zero.
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         rd_q <= 16'h0000;
      else if (reg_rd)
         case (reg_addr)
            PPM_CON_OFS:  rd_q <= con_q;
            PPM_MODE_OFS: rd_q <= {busy, mode_q[MODE_IRQ_HI:0]}; // R10
            PPM_ADDR_OFS: rd_q <= addr_q;
            PPM_AEN_OFS:  rd_q <= aen_q;
            PPM_DATA_OFS: rd_q <= rd_buf_q;
            default:      rd_q <= 16'h0000;
         endcase
      else
         rd_q <= 16'h0000;
   end

   // Pin functions; a level is ~(active ^ polarity), high when both set.
   assign cs2_act    = busy && addr_q[ADDR_SEL2]; // R20
   assign cs1_act    = busy && addr_q[ADDR_SEL1]; // R20
   assign data_phase = st_q == ST_SETUP || st_q == ST_STRB || st_q == ST_HOLD;
   assign wr_act     = st_q == ST_STRB && (m1 || dir_wr_q); // R8 R14
   assign rd_act     = m1 ? (st_q != ST_IDLE && !dir_wr_q)
                          : (st_q == ST_STRB && !dir_wr_q); // R9

   always_comb
   begin
      addr_val = addr_q;
      if (chip_sel_function == CSF_BOTH || chip_sel_function == CSF_TWO)
         addr_val[ADDR_SEL2] = ~(cs2_act ^ con_q[CON_SEL_TWO_POLARITY]); // R5 R6 R7
      if (chip_sel_function == CSF_BOTH)
         addr_val[ADDR_SEL1] = ~(cs1_act ^ con_q[CON_SEL_ONE_POLARITY]); // R5 R6 R7
      if (mux_on)
      begin
         addr_val[0] = ~((st_q == ST_ALO) ^ con_q[CON_ALP]); // R6 R23
         addr_val[1] = ~((st_q == ST_AHI) ^ con_q[CON_ALP]); // R6 R23
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         data_pins_out  <= 8'h00;
         data_pins_oe_n <= 1'b1;
         addr_pins_out  <= 16'h0000;
         addr_pins_oe_n <= 16'hffff;
         byte_en_out    <= 1'b0;
         byte_en_oe_n   <= 1'b1;
         wr_strobe_out  <= 1'b0;
         wr_strobe_oe_n <= 1'b1;
         rd_strobe_out  <= 1'b0;
         rd_strobe_oe_n <= 1'b1;
      end
      else
      begin
         if (st_q == ST_ALO)
            data_pins_out <= addr_q[7:0]; // R3 R23
         else if (st_q == ST_AHI)
            data_pins_out <= addr_q[15:8]; // R3
         else
            data_pins_out <= hi_q ? wr_buf_q[15:8] : wr_buf_q[7:0];
         data_pins_oe_n <= !(drive_en && (st_q == ST_ALO || st_q == ST_AHI
                                 || (dir_wr_q && data_phase)));
         addr_pins_out  <= addr_val;
         addr_pins_oe_n <= ~({16{drive_en}} & aen_q); // R22
         byte_en_out    <= ~((busy && wide) ^ con_q[CON_BEP]); // R6
         byte_en_oe_n   <= !(drive_en && con_q[CON_BE]); // R4
         wr_strobe_out  <= ~(wr_act ^ con_q[CON_WR_STROBE_POLARITY]); // R8
         wr_strobe_oe_n <= !(drive_en && con_q[CON_WR]); // R4
         rd_strobe_out  <= ~(rd_act ^ con_q[CON_RD_STROBE_POLARITY]); // R9
         rd_strobe_oe_n <= !(drive_en && con_q[CON_RD]); // R4
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   sequence lo_byte_s;
      st_q == ST_GAP && tcy_en && wide && !hi_q;
   endsequence
   sequence second_byte_s;
      hi_q && st_q != ST_IDLE;
   endsequence
   sequence addr_phase_s;
      drive_en && st_q == ST_ALO;
   endsequence
   port_off_a: // R1
      assert property (!port_on |=> st_q == ST_IDLE && data_pins_oe_n)
      else $error("Bus active while the port is off.");
   idle_freeze_a: // R2
      assert property (stop_when_idle && idle_mode && drive_en
                       |=> $stable(st_q) && $stable(cnt_q))
      else $error("Sequencer moved while stopped in idle.");
   strobe_pin_a: // R4
      assert property (!con_q[CON_WR] |=> wr_strobe_oe_n)
      else $error("Write strobe pin driven while disconnected.");
   sel_addr_a: // R7
      assert property (drive_en && chip_sel_function == 2'h0
                       |=> addr_pins_out[15:14] == $past(addr_q[15:14]))
      else $error("Address pins bent by select polarity.");
   wr_level_a: // R8
      assert property (drive_en && wr_act
                       |=> wr_strobe_out == $past(con_q[CON_WR_STROBE_POLARITY]))
      else $error("Write strobe level wrong.");
   busy_read_a: // R10
      assert property (reg_rd && reg_addr == PPM_MODE_OFS
                       |=> reg_rdata[MODE_BUSY] == $past(busy))
      else $error("Busy bit does not match sequencer state.");
   end_irq_a: // R11
      assert property (done && irq_mode == IRQ_END |=> xfer_irq)
      else $error("End-of-cycle pulse missing.");
   addr_up_a: // R12
      assert property (done && step_mode == INC_UP
                       && !(reg_wr && reg_addr == PPM_ADDR_OFS)
                       |=> addr_q[10:0] == $past(addr_q[10:0]) + 11'h001)
      else $error("Address did not step up by one.");
   two_bytes_a: // R13
      assert property (lo_byte_s |=> second_byte_s)
      else $error("Second byte of a wide transfer missing.");
   zero_wait_a: // R18
      assert property (st_q == ST_STRB && tcy_en && zero_wait
                       |=> st_q == ST_GAP)
      else $error("Hold phase used with zero strobe wait.");
   gap_hold_a: // R19
      assert property (st_q == ST_GAP && !tcy_en && drive_en |=> st_q == ST_GAP)
      else $error("Idle cycle between operations cut short.");
   latch_low_a: // R23
      assert property (addr_phase_s
                       |=> addr_pins_out[0] == $past(con_q[CON_ALP])
                       && data_pins_out == $past(addr_q[7:0]))
      else $error("Low latch strobe or address byte missing.");
endmodule
`default_nettype wire

// >>> tb/ppm_ext_dev.sv
`timescale 1ns/10ps
`default_nettype none
module ppm_ext_dev (
   input  wire logic        clk_sys,
   input  wire logic [15:0] a_pins,
   input  wire logic [7:0]  d_pins,
   input  wire logic        wr_pin,
   input  wire logic        wr_oe_n,
   input  wire logic        rd_pin,
   input  wire logic        rd_oe_n,
   input  wire logic        wpol,
   input  wire logic        rpol,
   input  wire logic        latch_polarity,
   input  wire logic        mode1,
   input  wire logic        muxed,
   output logic      [7:0]  d_to_port
);
   logic [7:0] mem [256];
   logic [7:0] lat_q;
   logic [7:0] last_q = 8'h00;
   logic       en_act;
   logic       rw_act;
   logic       wen;
   logic       ren;
   logic [7:0] ix;
   assign en_act = !wr_oe_n && wr_pin == wpol;
   assign rw_act = !rd_oe_n && rd_pin == rpol;
   assign wen = mode1 ? en_act && !rw_act : en_act;
   assign ren = mode1 ? en_act && rw_act : rw_act;
   assign ix = muxed ? lat_q : a_pins[7:0];
   // Outside a read window the lines float, shown as a toggling pattern.
   assign d_to_port = ren ? mem[ix] : ~last_q;
   always_ff @(posedge clk_sys)
   begin
      last_q <= d_to_port;
      if (muxed && a_pins[0] == latch_polarity) lat_q <= d_pins;
      if (wen) mem[ix] <= d_pins;
   end
endmodule
`default_nettype wire

// >>> tb/ppm_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ppm_core_tb
   import ppm_pkg::*;
;
   localparam int T = TCY_CLKS;
   logic        clk_sys, sys_rst, idle_mode, reg_wr, reg_rd;
   logic [7:0]  reg_addr, d_in, d_out;
   logic [15:0] reg_wdata, reg_rdata, a_out, a_oe_n, v;
   logic        d_oe_n, be_out, be_oe_n, wr_out, wr_oe_n, rd_out, rd_oe_n;
   logic        xfer_irq, cpu_stall, wpol, rpol, latch_polarity, mode1, muxed;
   logic [1:0]  sel_q;
   int          bad_count, tests_run, cyc;
   int          wr_cnt, rd_cnt, al_cnt, ah_cnt, dr_cnt, irq_cnt, be_cnt;

   ppm_core dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .idle_mode(idle_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .data_pins_in(d_in), .data_pins_out(d_out), .data_pins_oe_n(d_oe_n),
      .addr_pins_out(a_out), .addr_pins_oe_n(a_oe_n),
      .byte_en_out(be_out), .byte_en_oe_n(be_oe_n),
      .wr_strobe_out(wr_out), .wr_strobe_oe_n(wr_oe_n),
      .rd_strobe_out(rd_out), .rd_strobe_oe_n(rd_oe_n),
      .xfer_irq(xfer_irq), .cpu_stall(cpu_stall));

   ppm_ext_dev ext_u (.clk_sys(clk_sys), .a_pins(a_out), .d_pins(d_out),
      .wr_pin(wr_out), .wr_oe_n(wr_oe_n), .rd_pin(rd_out),
      .rd_oe_n(rd_oe_n), .wpol(wpol), .rpol(rpol), .latch_polarity(latch_polarity),
      .mode1(mode1), .muxed(muxed), .d_to_port(d_in));

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Counts the clocks during which each pin shows its active level.
   always @(posedge clk_sys)
   begin
      cyc++;
      if (!wr_oe_n && wr_out == wpol)
      begin
         wr_cnt++;
         sel_q = a_out[15:14];
      end
      if (!rd_oe_n && rd_out == rpol) rd_cnt++;
      if (!a_oe_n[0] && a_out[0] == latch_polarity) al_cnt++;
      if (!a_oe_n[1] && a_out[1] == latch_polarity) ah_cnt++;
      if (!d_oe_n) dr_cnt++;
      if (xfer_irq === 1'b1) irq_cnt++;
      // Every transfer scenario leaves the byte enable polarity bit clear.
      if (!be_oe_n && be_out === 1'b0) be_cnt++;
      if (cyc == 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp) bad_count++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         rd(PPM_MODE_OFS, v);
         n++;
      end while (v[15] !== 1'b0 && n < 300);
      chk({15'h0, v[15]}, 16'h0000);
   endtask

   task automatic go(input logic [15:0] c, input logic [15:0] m,
                     input logic [15:0] a);
      wr(PPM_CON_OFS, c);
      wr(PPM_MODE_OFS, m);
      wr(PPM_ADDR_OFS, a);
      #1;
      {wr_cnt, rd_cnt, al_cnt, ah_cnt, dr_cnt, irq_cnt, be_cnt} = '0;
   endtask

   task automatic xfer(input logic [15:0] c, input logic [15:0] m,
                       input logic [15:0] a, input logic [15:0] d);
      go(c, m, a);
      wr(PPM_DATA_OFS, d);
      wait_idle();
   endtask

   initial
   begin
      {idle_mode, reg_wr, reg_rd, mode1, muxed} = '0;
      {reg_addr, reg_wdata, bad_count, tests_run, cyc} = '0;
      {wpol, rpol, latch_polarity, sys_rst} = 4'hf;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         rd(8'(i * 4), v);
         chk(v, 16'h0000);
      end
      wr(PPM_CON_OFS, 16'hffff);
      rd(PPM_CON_OFS, v);
      chk(v, 16'hbfff);
      wr(PPM_MODE_OFS, 16'hffff);
      rd(PPM_MODE_OFS, v);
      chk(v, 16'h7fff);
      wr(PPM_ADDR_OFS, 16'hc3a5);
      rd(PPM_ADDR_OFS, v);
      chk(v, 16'hc3a5);
      wr(PPM_AEN_OFS, 16'hffff);
      rd(PPM_AEN_OFS, v);
      chk(v, 16'hffff);
      wr(8'h14, 16'hffff);
      rd(8'h14, v);
      chk(v, 16'h0000);
      $display("test registers finished");
      for (int i = 0; i < 2; i++)
      begin
         go(i ? 16'h8723 : 16'h0723, i ? 16'h2000 : 16'h2200, 16'h0050);
         wr(PPM_DATA_OFS, 16'h00ee);
         repeat (20) @(posedge clk_sys);
         chk(16'(wr_cnt + irq_cnt), 16'h0000);
      end
      $display("test port off and slave finished");
      xfer(16'h8723, 16'h2a00, 16'h0012, 16'h005a);
      chk({8'h00, ext_u.mem[8'h12]}, 16'h005a);
      chk(16'(wr_cnt), 16'(T));
      chk(16'(irq_cnt), 16'h0001);
      chk(16'(be_cnt), 16'h0000);
      rd(PPM_ADDR_OFS, v);
      chk(v, 16'h0013);
      $display("test plain write finished");
      muxed = 1'b1;
      xfer(16'h9723, 16'h064e, 16'h0034, 16'ha55a);
      chk({8'h00, ext_u.mem[8'h34]}, 16'h00a5);
      chk(16'(wr_cnt), 16'(8 * T));
      chk(16'(al_cnt), 16'(4 * T));
      chk(16'(ah_cnt), 16'(4 * T));
      chk(16'(dr_cnt), 16'(26 * T));
      chk(16'(be_cnt > 28 * T && be_cnt <= 29 * T), 16'h0001);
      xfer(16'h9723, 16'h02c3, 16'h0034, 16'h0077);
      chk(16'(al_cnt), 16'(T));
      chk(16'(dr_cnt), 16'(3 * T));
      xfer(16'h8f73, 16'h0200, 16'hc056, 16'h0042);
      chk({8'h00, ext_u.mem[8'h56]}, 16'h0042);
      chk(16'(al_cnt + ah_cnt), 16'(T));
      chk({14'h0, sel_q}, 16'h0003);
      muxed = 1'b0;
      $display("test multiplexed waits finished");
      go(16'h8723, 16'h1208, 16'h0012);
      rd(PPM_DATA_OFS, v);
      wait_idle();
      chk(16'(rd_cnt), 16'(3 * T));
      rd(PPM_DATA_OFS, v);
      chk(v, 16'h005a);
      wait_idle();
      rd(PPM_ADDR_OFS, v);
      chk(v, 16'h0010);
      $display("test read finished");
      wr(PPM_AEN_OFS, 16'hc000);
      xfer(16'h8793, 16'h0200, 16'h8001, 16'h0011);
      chk({14'h0, sel_q}, 16'h0003);
      xfer(16'h873b, 16'h0200, 16'h4000, 16'h0011);
      chk({14'h0, sel_q}, 16'h0001);
      $display("test selects finished");
      wpol = 1'b0;
      mode1 = 1'b1;
      xfer(16'h8721, 16'h0300, 16'h0020, 16'h003c);
      chk({8'h00, ext_u.mem[8'h20]}, 16'h003c);
      chk(16'(wr_cnt), 16'(T));
      wpol = 1'b1;
      mode1 = 1'b0;
      $display("test master mode one finished");
      @(posedge clk_sys);
      idle_mode <= 1'b1;
      go(16'ha723, 16'h4200, 16'h0060);
      wr(PPM_DATA_OFS, 16'h0099);
      repeat (20) @(posedge clk_sys);
      chk(16'(wr_cnt), 16'h0000);
      chk({15'h0, cpu_stall}, 16'h0001);
      idle_mode <= 1'b0;
      wait_idle();
      chk(16'(wr_cnt), 16'(T));
      chk(16'(irq_cnt), 16'h0000);
      $display("test idle and stall finished");
      end_of_test();
   end
endmodule
`default_nettype wire
